// ===== src/sync_timing.sv
// ccd horizontal and vertical sync timing with black clamp and blanking
`timescale 1ns/1ps
// Function
// R1: sync pin used only in master mode
// R2: sync polarity bit, active low after reset
// R3: sync count zero ignores sync input
// R4: sync count one resyncs every pulse
// R5: counts two to fourteen resync after nth
// R6: fifteen resyncs once after first pulse
// R7: horizontal drive low at line start
// R8: eleven bit line counter to field length
// R9: twelve bit pixel counter to gray length
// R10: line lasts four cycles beyond programmed length
// R11: software writes lengths in gray code
// R12: drive rise from secondary ten bit counter
// R13: vertical drive rise at line position
// R14: clamp toggles at two gray positions
// R15: no clamp in unequal last line
// R16: clamp master enable gates all regions
// R17: region mode overrides region enables
// R18: five region enables gate clamp
// R19: disabled region also masks next first line
// R20: region zero starts at vertical drive fall
// R21: blanking level mask sets clock a level
// R22: normal blanking blanks while drive low
// R23: clock b opposite of a in blanking
// R24: pulse count bit allows blanking pulses
// R25: region boundaries are eight bit lines
// R26: qualifying sync restarts pixel, secondary and line counters
module sync_timing
    import sync_timing_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [15:0] reg_rdata,
    // external sync pin
    input  wire logic        ext_sync,
    // timing outputs
    output logic             horizontal_drive,
    output logic             vertical_drive,
    output logic             black_clamp_pulse,
    output logic             horizontal_clock_a,
    output logic             horizontal_clock_b
);

    // binary to gray conversion, used for all gray compares
    function automatic logic [11:0] to_gray(input logic [11:0] b);
        return b ^ (b >> 1);
    endfunction

    // settings
    logic        follower_mode_select;          // 1 = follower, sync pin unused
    logic        sync_polarity;                 // 1 = active high
    logic        clamp_master_enable;           // clamp on/off
    logic        clamp_region_mode;             // 1 = ignore region enables
    logic        blanking_level_mask;           // clock a level in blanking
    logic        blanking_pulse_count;          // pulses during blanking
    logic [3:0]  sync_count_select;             // sync qualification mode
    logic [11:0] line_length_gray;              // regular line length
    logic [11:0] last_line_length_gray;         // last line length
    logic [9:0]  secondary_line_length;         // secondary counter length
    logic [9:0]  hdrive_rise_position;          // drive rise on secondary count
    logic [10:0] field_line_count;              // lines per field
    logic [3:0]  vdrive_rise_position;          // vertical rise line
    logic [11:0] clamp_toggle_first;            // first clamp toggle
    logic [11:0] clamp_toggle_second;           // second clamp toggle
    logic [4:0]  clamp_enable_region;           // per region enables
    logic [7:0]  region_boundary_line [1:4];    // boundaries of regions 1..4

    // counters and state
    logic [11:0] pix_reg;                       // horizontal pixel counter
    logic [9:0]  sec_reg;                       // secondary line counter
    logic [10:0] line_reg;                      // vertical line counter
    logic [2:0]  region_reg;                    // current region
    logic        first_line_reg;                // first line of a region
    logic        prev_off_reg;                  // previous region clamp disabled
    logic        clamp_tog_reg;                 // raw clamp toggle state
    logic        sync_prev_reg;                 // last sync level (asserted form)
    logic [3:0]  sync_seen_reg;                 // qualified pulses counted
    logic        sync_once_done_reg;            // once-mode already used
    logic        blank_phase_reg;               // pulse phase during blanking

    // derived values
    logic [11:0] cur_len;
    logic        line_end;
    logic        field_end;
    logic        last_line;
    logic        sync_asserted;
    logic        sync_edge;
    logic        resync;
    logic        region_ok;
    logic        clamp_next;

    // current line length; last line uses its own length
    assign last_line = (line_reg + 11'h001 == field_line_count);
    assign cur_len   = last_line ? last_line_length_gray : line_length_gray;
    // line ends after programmed length plus the setup cycles, counts 0 to n+3
    assign line_end  = (to_gray(pix_reg - SETUP_CYCLES + 12'h001) == cur_len)
                       && (pix_reg >= SETUP_CYCLES - 12'h001); // R9 R10
    assign field_end = line_end && last_line; // R8

    // sync input qualification
    assign sync_asserted = sync_polarity ? ext_sync : ~ext_sync; // R2
    assign sync_edge = sync_asserted && !sync_prev_reg && !follower_mode_select; // R1

    // decide whether this edge restarts timing
    always_comb begin
        resync = 1'b0;
        if (sync_edge) begin
            case (sync_count_select)
                SYNC_OFF:   resync = 1'b0; // R3
                SYNC_EVERY: resync = 1'b1; // R4
                SYNC_ONCE:  resync = !sync_once_done_reg; // R6
                default:    resync = (sync_seen_reg + 4'h1 == sync_count_select); // R5
            endcase
        end
    end

    // register writes
    always_ff @(posedge clk) begin
        if (reset) begin
            follower_mode_select  <= RST_FOLLOWER; // R1
            sync_polarity         <= RST_SYNC_POL; // R2
            clamp_master_enable   <= 1'b0;
            clamp_region_mode     <= 1'b0;
            blanking_level_mask   <= 1'b0;
            blanking_pulse_count  <= 1'b0;
            sync_count_select     <= RST_SYNC_CNT;
            line_length_gray      <= RST_LINE_LEN;
            last_line_length_gray <= RST_LINE_LEN;
            secondary_line_length <= RST_SEC_LEN;
            hdrive_rise_position  <= RST_HD_RISE;
            field_line_count      <= RST_FIELD_LEN;
            vdrive_rise_position  <= RST_VD_RISE;
            clamp_toggle_first    <= RST_CLP_TOG;
            clamp_toggle_second   <= RST_CLP_TOG;
            clamp_enable_region   <= RST_CLP_EN;
            for (int i = 1; i <= 4; i++) begin
                region_boundary_line[i] <= 8'h00;
            end
        end else if (reg_write) begin
            case (reg_addr)
                ADDR_CTRL: begin
                    sync_polarity       <= reg_wdata[CTRL_SYNC_POL];
                    clamp_master_enable <= reg_wdata[CTRL_CLP_MASTER];
                    clamp_region_mode   <= reg_wdata[CTRL_CLP_MODE];
                    blanking_level_mask <= reg_wdata[CTRL_BLANK_LVL];
                end
                ADDR_SYNC: begin
                    sync_count_select    <= reg_wdata[3:0];
                    blanking_pulse_count <= reg_wdata[SYNC_BLANK_PULSE];
                end
                ADDR_FOLLOWER:  follower_mode_select  <= reg_wdata[0];
                ADDR_LINE_LEN:  line_length_gray      <= reg_wdata[11:0];
                ADDR_SEC_LEN:   secondary_line_length <= reg_wdata[9:0];
                ADDR_HD_RISE:   hdrive_rise_position  <= reg_wdata[9:0];
                ADDR_LAST_LEN:  last_line_length_gray <= reg_wdata[11:0];
                ADDR_FIELD_LEN: field_line_count      <= reg_wdata[10:0];
                ADDR_VD_RISE:   vdrive_rise_position  <= reg_wdata[3:0];
                ADDR_CLP_TOG1:  clamp_toggle_first    <= reg_wdata[11:0];
                ADDR_CLP_TOG2:  clamp_toggle_second   <= reg_wdata[11:0];
                ADDR_CLP_EN:    clamp_enable_region   <= reg_wdata[4:0];
                ADDR_BOUND01: begin
                    region_boundary_line[1] <= reg_wdata[7:0]; // R25
                    region_boundary_line[2] <= reg_wdata[15:8];
                end
                ADDR_BOUND23: begin
                    region_boundary_line[3] <= reg_wdata[7:0];
                    region_boundary_line[4] <= reg_wdata[15:8];
                end
                default: begin
                end
            endcase
        end
    end

    // register reads, data one cycle after the strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read) begin
            case (reg_addr)
                ADDR_CTRL: reg_rdata <= {12'h000, blanking_level_mask, clamp_region_mode,
                                         clamp_master_enable, sync_polarity};
                ADDR_SYNC:      reg_rdata <= {11'h000, blanking_pulse_count, sync_count_select};
                ADDR_FOLLOWER:  reg_rdata <= {15'h0000, follower_mode_select};
                ADDR_LINE_LEN:  reg_rdata <= {4'h0, line_length_gray};
                ADDR_SEC_LEN:   reg_rdata <= {6'h00, secondary_line_length};
                ADDR_HD_RISE:   reg_rdata <= {6'h00, hdrive_rise_position};
                ADDR_LAST_LEN:  reg_rdata <= {4'h0, last_line_length_gray};
                ADDR_FIELD_LEN: reg_rdata <= {5'h00, field_line_count};
                ADDR_VD_RISE:   reg_rdata <= {12'h000, vdrive_rise_position};
                ADDR_CLP_TOG1:  reg_rdata <= {4'h0, clamp_toggle_first};
                ADDR_CLP_TOG2:  reg_rdata <= {4'h0, clamp_toggle_second};
                ADDR_CLP_EN:    reg_rdata <= {11'h000, clamp_enable_region};
                ADDR_BOUND01:   reg_rdata <= {region_boundary_line[2], region_boundary_line[1]};
                ADDR_BOUND23:   reg_rdata <= {region_boundary_line[4], region_boundary_line[3]};
                ADDR_STATUS:    reg_rdata <= {2'b00, region_reg, line_reg};
                default:        reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // sync edge tracking and pulse counting
    always_ff @(posedge clk) begin
        if (reset) begin
            sync_prev_reg      <= 1'b0;
            sync_seen_reg      <= 4'h0;
            sync_once_done_reg <= 1'b0;
        end else begin
            sync_prev_reg <= sync_asserted;
            if (sync_edge && sync_count_select != SYNC_OFF) begin
                sync_seen_reg <= resync ? 4'h0 : sync_seen_reg + 4'h1; // R5
                // only a once-mode resync uses up the single allowed restart
                if (resync && sync_count_select == SYNC_ONCE) begin
                    sync_once_done_reg <= 1'b1; // R6
                end
            end
        end
    end

    // pixel, secondary and line counters
    always_ff @(posedge clk) begin
        if (reset || resync) begin
            pix_reg  <= 12'h000; // R26
            sec_reg  <= 10'h000;
            line_reg <= 11'h000;
        end else begin
            if (line_end) begin
                pix_reg <= 12'h000;
                sec_reg <= 10'h000;
                line_reg <= field_end ? 11'h000 : line_reg + 11'h001; // R8
            end else begin
                pix_reg <= pix_reg + 12'h001;
                sec_reg <= (sec_reg == secondary_line_length) ? sec_reg
                           : sec_reg + 10'h001; // R12
            end
        end
    end

    // drive outputs
    always_ff @(posedge clk) begin
        if (reset) begin
            horizontal_drive <= 1'b1;
            vertical_drive   <= 1'b1;
        end else if (resync || line_end) begin
            horizontal_drive <= 1'b0; // R7
            if (resync || field_end) begin
                vertical_drive <= 1'b0;
            end else if (line_reg + 11'h001 == {7'h00, vdrive_rise_position}) begin
                vertical_drive <= 1'b1; // R13
            end
        end else if (sec_reg == hdrive_rise_position) begin
            horizontal_drive <= 1'b1; // R12
        end
    end

    // region tracking; region zero starts at the field start
    always_ff @(posedge clk) begin
        if (reset || resync) begin
            region_reg     <= 3'd0; // R20
            first_line_reg <= 1'b1;
            prev_off_reg   <= 1'b0;
        end else if (line_end) begin
            if (field_end) begin
                region_reg     <= 3'd0; // R20
                first_line_reg <= 1'b1;
                prev_off_reg   <= !clamp_enable_region[region_reg];
            end else if (region_reg < 3'd4 &&
                         line_reg[7:0] + 8'h01 == region_boundary_line[region_reg + 3'd1]) begin
                region_reg     <= region_reg + 3'd1; // R25
                first_line_reg <= 1'b1;
                prev_off_reg   <= !clamp_enable_region[region_reg]; // R19
            end else begin
                first_line_reg <= 1'b0;
            end
        end
    end

    // clamp gating per region and line
    always_comb begin
        if (clamp_region_mode) begin
            region_ok = 1'b1; // R17
        end else begin
            region_ok = clamp_enable_region[region_reg] // R18
                        && !(first_line_reg && prev_off_reg); // R19
        end
        clamp_next = clamp_tog_reg && clamp_master_enable && region_ok // R16
                     && !(last_line && last_line_length_gray != line_length_gray); // R15
    end

    // raw clamp toggling and the clamp output
    always_ff @(posedge clk) begin
        if (reset || resync || line_end) begin
            clamp_tog_reg     <= 1'b0;
            black_clamp_pulse <= 1'b0;
        end else begin
            if (to_gray(pix_reg) == clamp_toggle_first ||
                to_gray(pix_reg) == clamp_toggle_second) begin
                clamp_tog_reg <= !clamp_tog_reg; // R14
            end
            black_clamp_pulse <= clamp_next;
        end
    end

    // horizontal clocks; blanked while drive low
    always_ff @(posedge clk) begin
        if (reset) begin
            blank_phase_reg    <= 1'b0;
            horizontal_clock_a <= 1'b0;
            horizontal_clock_b <= 1'b1;
        end else begin
            blank_phase_reg <= !blank_phase_reg;
            if (!horizontal_drive && !blanking_pulse_count) begin
                horizontal_clock_a <= blanking_level_mask; // R21 R22
                horizontal_clock_b <= !blanking_level_mask; // R23
            end else begin
                horizontal_clock_a <= blank_phase_reg; // R24
                horizontal_clock_b <= !blank_phase_reg; // R23
            end
        end
    end

    // checks
    // drive falls on the edge after every line end
    hd_low_line_a: assert property ( // R7
        @(posedge clk) disable iff (reset) line_end |=> !horizontal_drive)
        else $error("drive not low at line start");
    // clock a holds the mask level through normal blanking
    blank_level_a: assert property ( // R21
        @(posedge clk) disable iff (reset) (!horizontal_drive && !blanking_pulse_count)
        |=> horizontal_clock_a == $past(blanking_level_mask))
        else $error("blank level wrong");
    // clock b is always the inverse of clock a
    clock_invert_a: assert property ( // R23
        @(posedge clk) disable iff (reset) ##1 horizontal_clock_b == !horizontal_clock_a)
        else $error("clocks not opposite");
    // master control off keeps the clamp low everywhere
    clamp_master_a: assert property ( // R16
        @(posedge clk) disable iff (reset) !clamp_master_enable |=> !black_clamp_pulse)
        else $error("clamp while off");
    // sync count zero never restarts the timing
    sync_off_a: assert property ( // R3
        @(posedge clk) disable iff (reset) (sync_count_select == SYNC_OFF) |-> !resync)
        else $error("sync not ignored");
    // in follower mode the sync pin has no effect
    follower_sync_a: assert property ( // R1
        @(posedge clk) disable iff (reset) follower_mode_select |-> !resync)
        else $error("sync in follower mode");
    // a restart clears the pixel and line counters and lowers vertical drive
    resync_restart_a: assert property ( // R26
        @(posedge clk) disable iff (reset)
        resync |=> (pix_reg == 12'h000 && line_reg == 11'h000 && !vertical_drive))
        else $error("no restart on sync");
    // an unequal last line carries no clamp
    last_line_a: assert property ( // R15
        @(posedge clk) disable iff (reset)
        (last_line && last_line_length_gray != line_length_gray) |=> !black_clamp_pulse)
        else $error("clamp in unequal last line");
    // count one restarts on every qualified edge
    every_sync_a: assert property ( // R4
        @(posedge clk) disable iff (reset)
        (sync_edge && sync_count_select == SYNC_EVERY) |-> resync)
        else $error("sync pulse missed");
    // once mode never restarts a second time
    once_sync_a: assert property ( // R6
        @(posedge clk) disable iff (reset)
        (sync_once_done_reg && sync_count_select == SYNC_ONCE) |-> !resync)
        else $error("second resync in once mode");

endmodule

// ===== src/sync_timing_pkg.sv
// constants for the ccd sync, clamp and blanking timing block
package sync_timing_pkg;
    // register indices on the plain register port
    localparam logic [7:0] ADDR_CTRL      = 8'h01;  // sync polarity, clamp control, blank level
    localparam logic [7:0] ADDR_SYNC      = 8'h0a;  // sync count, blank pulse count
    localparam logic [7:0] ADDR_FOLLOWER  = 8'hd6;  // follower (slave) mode select
    localparam logic [7:0] ADDR_LINE_LEN  = 8'h10;  // line length gray
    localparam logic [7:0] ADDR_SEC_LEN   = 8'h11;  // secondary line length
    localparam logic [7:0] ADDR_HD_RISE   = 8'h12;  // horizontal drive rise position
    localparam logic [7:0] ADDR_LAST_LEN  = 8'h13;  // last line length gray
    localparam logic [7:0] ADDR_FIELD_LEN = 8'h14;  // field line count
    localparam logic [7:0] ADDR_VD_RISE   = 8'h15;  // vertical drive rise position
    localparam logic [7:0] ADDR_CLP_TOG1  = 8'h16;  // clamp toggle first
    localparam logic [7:0] ADDR_CLP_TOG2  = 8'h17;  // clamp toggle second
    localparam logic [7:0] ADDR_CLP_EN    = 8'h18;  // region clamp enables
    localparam logic [7:0] ADDR_BOUND01   = 8'h19;  // region boundaries 1 and 2
    localparam logic [7:0] ADDR_BOUND23   = 8'h1a;  // region boundaries 3 and 4
    localparam logic [7:0] ADDR_STATUS    = 8'h1b;  // line counter and region, read only
    // control register field positions
    localparam int CTRL_SYNC_POL  = 0;
    localparam int CTRL_CLP_MASTER = 1;
    localparam int CTRL_CLP_MODE  = 2;
    localparam int CTRL_BLANK_LVL = 3;
    localparam int SYNC_BLANK_PULSE = 4;
    // reset values
    localparam logic        RST_FOLLOWER  = 1'b1;   // comes up as follower
    localparam logic        RST_SYNC_POL  = 1'b0;   // sync input active low
    localparam logic [3:0]  RST_SYNC_CNT  = 4'h0;
    localparam logic [11:0] RST_LINE_LEN  = 12'h0c28;
    localparam logic [10:0] RST_FIELD_LEN = 11'h07d0;
    localparam logic [9:0]  RST_SEC_LEN   = 10'h03ff;
    localparam logic [9:0]  RST_HD_RISE   = 10'h0010;
    localparam logic [3:0]  RST_VD_RISE   = 4'h2;
    localparam logic [11:0] RST_CLP_TOG   = 12'h0000;
    localparam logic [4:0]  RST_CLP_EN    = 5'h1f;
    // sync count codes
    localparam logic [3:0] SYNC_OFF   = 4'h0;
    localparam logic [3:0] SYNC_EVERY = 4'h1;
    localparam logic [3:0] SYNC_ONCE  = 4'hf;
    // line setup delay in clock cycles
    localparam logic [11:0] SETUP_CYCLES = 12'h0004;
    localparam int NUM_REGIONS = 5;
endpackage

// ===== verif/ccd_sync_clamp_blank_timing_tb_top.sv
// self-checking bench for the sync, clamp and blanking timing block
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module ccd_sync_clamp_blank_timing_tb_top;
    import sync_timing_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [15:0] reg_rdata;
    logic ext_sync, fire = 1'b0, pol = 1'b0;
    logic horizontal_drive, vertical_drive, black_clamp_pulse;
    logic horizontal_clock_a, horizontal_clock_b;
    int num_errors = 0, tests_run = 0, cycles = 0, n, k;
    logic [15:0] d;
    sync_timing i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .ext_sync(ext_sync),
        .horizontal_drive(horizontal_drive), .vertical_drive(vertical_drive),
        .black_clamp_pulse(black_clamp_pulse), .horizontal_clock_a(horizontal_clock_a),
        .horizontal_clock_b(horizontal_clock_b));
    sync_source_model i_src (.clk(clk), .active_high(pol), .fire(fire), .ext_sync(ext_sync));
    // 50 MHz clock
    initial begin
        forever #10 clk = ~clk;
    end
    // verdict and end of run
    task conclude;
        $display("errors %0d of %0d comparisons", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 90000) begin
            num_errors++;
            conclude();
        end
    end
    // lengths are handed over in gray code
    function logic [11:0] gray(input logic [11:0] b);
        return b ^ (b >> 1);
    endfunction
    function logic pick(input bit v);
        return v ? vertical_drive : horizontal_drive;
    endfunction
    // one cycle register write and read
    task wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task pulse;
        @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
    endtask
    // cycles between two falling edges of a drive output
    task gap(input bit v, output int c);
        logic p;
        do begin p = pick(v); @(posedge clk); #1; end while (!(p === 1'b1 && pick(v) === 1'b0));
        c = 0;
        do begin p = pick(v); @(posedge clk); #1; c++; end while (!(p === 1'b1 && pick(v) === 1'b0));
    endtask
    // reset, short lines of 20 cycles, 200 line field, then resync and pick the mode
    task setup(input logic p, input logic [3:0] cnt, input logic fol);
        reset <= 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        pol <= p;
        wr(ADDR_LINE_LEN, {4'h0, gray(12'd16)});
        wr(ADDR_LAST_LEN, {4'h0, gray(12'd16)});
        wr(ADDR_HD_RISE, 16'h0008);
        wr(ADDR_FIELD_LEN, 16'd200);
        wr(ADDR_BOUND01, 16'hffff);
        wr(ADDR_BOUND23, 16'hffff);
        wr(ADDR_CTRL, {15'h0, p});
        wr(ADDR_FOLLOWER, 16'h0000);
        wr(ADDR_SYNC, 16'h0001);
        pulse();
        wr(ADDR_SYNC, {12'h0, cnt});
        wr(ADDR_FOLLOWER, {15'h0, fol});
    endtask
    // a pulse after a random pause; a resync shows line zero right after
    task sync_chk(input logic exp);
        repeat (40 + $urandom % 160) @(posedge clk);
        pulse();
        rd(ADDR_STATUS, d);
        `CHK(d[10:0] === 11'h000, exp)
    endtask
    task blank_chk(input logic m, input logic pc);
        logic p, pa;
        wr(ADDR_CTRL, {12'h0, m, 3'b000});
        wr(ADDR_SYNC, {11'h0, pc, 4'h1});
        repeat (25) @(posedge clk);
        #1 p = horizontal_drive;
        pa = horizontal_clock_a;
        k = 0;
        repeat (100) begin
            @(posedge clk);
            #1 `CHK(horizontal_clock_b, ~horizontal_clock_a)
            if (p === 1'b0 && horizontal_drive === 1'b0) begin
                if (!pc) `CHK(horizontal_clock_a, m)
                else if (horizontal_clock_a !== pa) k++;
            end
            p = horizontal_drive;
            pa = horizontal_clock_a;
        end
        if (pc) `CHK(k > 0, 1'b1)
    endtask
    logic [7:0] ra[3] = '{ADDR_CLP_TOG1, ADDR_HD_RISE, ADDR_FIELD_LEN};
    logic [15:0] rm[3] = '{16'h0fff, 16'h03ff, 16'h07ff};
    logic [15:0] cc[4] = '{16'h0000, 16'h0002, 16'h0002, 16'h0006};
    logic [15:0] ce[4] = '{16'h001f, 16'h001f, 16'h001e, 16'h0000};
    logic ex[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    initial begin
        n = $urandom(32'h1df2);
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        rd(ADDR_FOLLOWER, d);
        `CHK(d[0], 1'b1)
        rd(ADDR_CTRL, d);
        `CHK(d[0], 1'b0)
        rd(ADDR_SYNC, d);
        `CHK(d[3:0], 4'h0)
        rd(8'h80, d);
        `CHK(d, 16'h0000)
        for (int i = 0; i < 12; i++) begin
            reg_wdata <= $urandom;
            wr(ra[i % 3], $urandom & rm[i % 3]);
            rd(ra[i % 3], d);
            `CHK(d, reg_wdata & rm[i % 3])
        end
        setup(1'b0, 4'h1, 1'b0);
        gap(1'b0, n);
        `CHK(n, 20)
        gap(1'b1, n);
        `CHK(n, 4000)
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CTRL, cc[i]);
            wr(ADDR_CLP_EN, ce[i]);
            repeat (20) @(posedge clk);
            k = 0;
            repeat (200) begin @(posedge clk); #1 if (black_clamp_pulse === 1'b1) k++; end
            `CHK(k > 0, ex[i])
        end
        // a shorter last line carries no clamp, so a long quiet run ends the field
        wr(ADDR_LAST_LEN, {4'h0, gray(12'd10)});
        wait (vertical_drive === 1'b0);
        wait (vertical_drive === 1'b1);
        k = 0;
        do begin
            @(posedge clk);
            #1 k = (black_clamp_pulse === 1'b1) ? 0 : k + 1;
        end while (vertical_drive !== 1'b0);
        `CHK(k > 3, 1'b1)
        blank_chk(1'b0, 1'b0);
        blank_chk(1'b1, 1'b0);
        blank_chk(1'b0, 1'b1);
        sync_chk(1'b1);
        sync_chk(1'b1);
        setup(1'b1, 4'h1, 1'b0);
        sync_chk(1'b1);
        setup(1'b0, 4'h0, 1'b0);
        sync_chk(1'b0);
        setup(1'b0, 4'h1, 1'b1);
        sync_chk(1'b0);
        for (int m = 2; m <= 14; m++) begin
            setup(1'b0, m[3:0], 1'b0);
            for (int j = 1; j <= m; j++) sync_chk(j == m);
        end
        setup(1'b0, 4'hf, 1'b0);
        sync_chk(1'b1);
        sync_chk(1'b0);
        sync_chk(1'b0);
        conclude();
    end
endmodule

// ===== verif/sync_source_model.sv
// external sync pulse source standing in for the far-side sync generator
`timescale 1ns/1ps
module sync_source_model (
    // clock
    input  wire logic clk,
    // pulse polarity and trigger from the bench
    input  wire logic active_high,
    input  wire logic fire,
    // sync pin level
    output logic      ext_sync
);
    logic [1:0] left_reg = 2'h0;  // cycles of the pulse still to drive

    // a trigger starts a three cycle pulse
    always @(posedge clk) begin
        if (fire) begin
            left_reg <= 2'h3;
        end else if (left_reg != 2'h0) begin
            left_reg <= left_reg - 2'h1;
        end
    end

    // idle at the inactive level, asserted level during the pulse
    assign ext_sync = (left_reg != 2'h0) ? active_high : ~active_high;
endmodule
